// ==== hdl/nbu_uart.sv ====
// Behaviour
// RL1: character is eleven bit times long
// RL2: eight data bits lsb first, then ninth
// RL3: transmit ninth bit comes from tx_ninth_bit
// RL4: received ninth to rx_ninth_bit; stop unchecked
// RL5: writing serial_buffer starts a character; a write while busy is ignored
// RL6: tx_done_flag sets at stop bit start
// RL7: receive starts only with rx_enable_bit set
// RL8: accept if rx_done_flag clear and address ok
// RL9: accepted: store data, ninth, set rx_done_flag
// RL10: rejected character changes nothing
// RL11: either done flag raises the interrupt; here only its setting does, if its mask bit is set
// RL12: fixed rate is clock over 64 or 32
// RL13: baud_double_bit resets to zero
// RL14: variable rate from timer 1 or 2 overflows
// RL15: software clears both done flags itself
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.svh"
module nbu_uart
	import nbu_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer overflow pulses for the variable rate
	input wire logic tmr1_ovf,
	input wire logic tmr2_ovf,
	// serial line
	input wire logic rxd,
	output logic txd,
	// interrupt
	output logic irq
);
	// register state
	logic [7:0] ctrl; // serial_control_reg
	logic [7:0] pwr; // power_control_reg
	logic [7:0] rx_buf; // receive half of serial_buffer
	logic [1:0] stat; // sticky interrupt status
	logic [1:0] mask; // interrupt mask

	// bus decode
	logic setup_rd; // first access cycle, answer is prepared
	logic acc; // transfer completes at this edge
	logic wr; // completing write
	logic rd; // completing read
	logic hit_ctrl;
	logic hit_buf;
	logic hit_pwr;
	logic hit_stat;
	logic hit_mask;
	logic mapped;

	// engine links
	logic tick; // sixteen per bit
	nbu_char_type rx_char;
	logic rx_valid;
	logic rx_accept; // character passes the filter
	logic tx_set; // ninth bit ends
	logic tx_load; // software starts a character
	logic [1:0] evt; // events into status

	// transmitter
	nbu_tx_type tx_state;
	logic [3:0] tx_cnt;
	logic [3:0] tx_idx;
	logic [10:0] tx_shreg;
	logic tx_bit_end;
	logic ninth_sent; // ninth bit of the character on the line

	// one address compare shared by all registers
	function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] ofs);
		hit = (a == ADDR_WIDTH'(ofs));
	endfunction

	assign hit_ctrl = hit(paddr, `NBU_OFS_CTRL);
	assign hit_buf = hit(paddr, `NBU_OFS_BUF);
	assign hit_pwr = hit(paddr, `NBU_OFS_PWR);
	assign hit_stat = hit(paddr, `NBU_OFS_STAT);
	assign hit_mask = hit(paddr, `NBU_OFS_MASK);
	assign mapped = hit_ctrl | hit_buf | hit_pwr | hit_stat | hit_mask;

	// one wait state: pready rises in the second access cycle
	assign setup_rd = psel & penable & ~pready;
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;

	// bus answer flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_rd;
			pslverr <= setup_rd & ~mapped;
		end
	end

	// read data captured one edge ahead of completion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_rd && !pwrite)
		begin
			prdata <= 32'h0000_0000;
			if (hit_ctrl)
				prdata[7:0] <= ctrl;
			else if (hit_buf)
				prdata[7:0] <= rx_buf;
			else if (hit_pwr)
				prdata[7:0] <= pwr;
			else if (hit_stat)
				prdata[1:0] <= stat;
			else if (hit_mask)
				prdata[1:0] <= mask;
		end
	end

	// baud generator
	nbu_baud nbu_baud_i
	(
		.pclk(pclk),
		.presetn(presetn),
		.variable_rate(ctrl[`NBU_VAR]),
		.use_timer2(ctrl[`NBU_T2SEL]),
		.baud_double_bit(pwr[`NBU_DOUBLE]),
		.tmr1_ovf(tmr1_ovf),
		.tmr2_ovf(tmr2_ovf),
		.tick(tick)
	);

	// receiver
	nbu_rx nbu_rx_i
	(
		.pclk(pclk),
		.presetn(presetn),
		.rx_enable(ctrl[`NBU_REN]),
		.tick(tick),
		.rxd(rxd),
		.rx_char(rx_char),
		.rx_valid(rx_valid)
	);

	// multiprocessor filter; a still-set rx_done_flag blocks it
	assign rx_accept = rx_valid & ~ctrl[`NBU_RX_DONE]
		& (~ctrl[`NBU_MPROC] | rx_char.ninth); // [RL8] [RL15]

	// receive buffer loads only on an accepted character
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_buf <= 8'h00;
		else if (rx_accept)
			rx_buf <= rx_char.data; // [RL9] [RL10]
	end

	// control register: hardware sets win over a software write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= `NBU_CTRL_RST;
		else
		begin
			if (wr && hit_ctrl)
				ctrl <= pwdata[7:0];
			if (rx_accept)
			begin
				ctrl[`NBU_RX_NINTH] <= rx_char.ninth; // [RL4] [RL9]
				ctrl[`NBU_RX_DONE] <= 1'b1; // [RL9]
			end
			if (tx_set)
				ctrl[`NBU_TX_DONE] <= 1'b1; // [RL6]
		end
	end

	// power control, only the rate doubler is kept
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwr <= `NBU_PWR_RST; // [RL13]
		else if (wr && hit_pwr)
			pwr <= pwdata[7:0] & (8'h01 << `NBU_DOUBLE);
	end

	// transmitter: a write while busy is ignored to protect the frame
	assign tx_load = wr & hit_buf & (tx_state == NBU_TX_IDLE); // [RL5]
	assign tx_bit_end = (tx_state == NBU_TX_SHIFT) & tick & (tx_cnt == `NBU_TICK_LAST);
	assign tx_set = tx_bit_end & (tx_idx == `NBU_IDX_NINTH); // [RL6]

	// transmit sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state <= NBU_TX_IDLE;
			tx_cnt <= 4'h0;
			tx_idx <= 4'h0;
			tx_shreg <= 11'h7FF;
			ninth_sent <= 1'b0;
			txd <= 1'b1;
		end
		else
		begin
			unique case (tx_state)
				NBU_TX_IDLE:
					if (tx_load)
					begin
						// stop, ninth, data, start [RL1] [RL2] [RL3]
						tx_shreg <= {1'b1, ctrl[`NBU_TX_NINTH], pwdata[7:0], 1'b0};
						ninth_sent <= ctrl[`NBU_TX_NINTH];
						tx_cnt <= 4'h0;
						tx_idx <= 4'h0;
						txd <= 1'b0;
						tx_state <= NBU_TX_SHIFT;
					end
				NBU_TX_SHIFT:
				begin
					if (tick)
						tx_cnt <= tx_cnt + 4'h1;
					if (tx_bit_end)
					begin
						tx_shreg <= {1'b1, tx_shreg[10:1]};
						txd <= tx_shreg[1]; // [RL2]
						tx_idx <= tx_idx + 4'h1;
						if (tx_idx == `NBU_IDX_STOP) // [RL1]
						begin
							txd <= 1'b1;
							tx_state <= NBU_TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// interrupt events follow the done flags being set
	assign evt[`NBU_IRQ_RX] = rx_accept; // [RL11]
	assign evt[`NBU_IRQ_TX] = tx_set; // [RL11]

	// sticky status; a read clears only what it returned, a new event wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat <= `NBU_IRQ_RST;
		else if (rd && hit_stat)
			stat <= (stat & ~prdata[1:0]) | evt;
		else
			stat <= stat | evt;
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask <= `NBU_IRQ_RST;
		else if (wr && hit_mask)
			mask <= pwdata[1:0];
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(stat & mask); // [RL11]
	end

	property p_load_start;
		@(posedge pclk) disable iff (!presetn)
		tx_load |=> (tx_state == NBU_TX_SHIFT) && !txd;
	endproperty
	a_load_start: assert property (p_load_start) else $error("write did not start a character"); // [RL5]

	property p_ninth_on_line;
		@(posedge pclk) disable iff (!presetn)
		tx_set |-> (txd == ninth_sent) ##1 txd;
	endproperty
	a_ninth_on_line: assert property (p_ninth_on_line) else $error("ninth bit or stop wrong"); // [RL3]

	property p_tx_done_set;
		@(posedge pclk) disable iff (!presetn)
		tx_set |=> ctrl[`NBU_TX_DONE] && (tx_idx == `NBU_IDX_STOP);
	endproperty
	a_tx_done_set: assert property (p_tx_done_set) else $error("tx_done_flag not set at stop"); // [RL6]

	property p_frame_len;
		@(posedge pclk) disable iff (!presetn)
		(tx_bit_end && tx_idx == `NBU_IDX_STOP) |=> (tx_state == NBU_TX_IDLE) && (tx_idx == `NBU_IDX_DONE);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not eleven bits"); // [RL1]

	property p_accept;
		@(posedge pclk) disable iff (!presetn)
		rx_accept |=> ctrl[`NBU_RX_DONE] && (rx_buf == $past(rx_char.data)) && (ctrl[`NBU_RX_NINTH] == $past(rx_char.ninth));
	endproperty
	a_accept: assert property (p_accept) else $error("accepted character not stored"); // [RL9]

	property p_reject;
		@(posedge pclk) disable iff (!presetn)
		(rx_valid && !rx_accept && !wr) |=> (rx_buf == $past(rx_buf)) && $stable(ctrl[`NBU_RX_DONE]) && $stable(ctrl[`NBU_RX_NINTH]);
	endproperty
	a_reject: assert property (p_reject) else $error("rejected character changed state"); // [RL10]

	property p_filter;
		@(posedge pclk) disable iff (!presetn)
		(rx_valid && !ctrl[`NBU_RX_DONE] && ctrl[`NBU_MPROC] && !rx_char.ninth && !wr) |=> !ctrl[`NBU_RX_DONE];
	endproperty
	a_filter: assert property (p_filter) else $error("address filter let data through"); // [RL8]

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(tx_set && mask[`NBU_IRQ_TX] && !(wr && hit_mask)) |-> ##2 irq;
	endproperty
	a_irq: assert property (p_irq) else $error("tx_done_flag raised no interrupt"); // [RL11]

	property p_double_reset;
		@(posedge pclk)
		$rose(presetn) |-> !pwr[`NBU_DOUBLE];
	endproperty
	a_double_reset: assert property (p_double_reset) else $error("baud_double_bit not zero after reset"); // [RL13]

	c_frame: cover property (@(posedge pclk) disable iff (!presetn) tx_set);
	c_accept: cover property (@(posedge pclk) disable iff (!presetn) rx_accept);
	c_reject: cover property (@(posedge pclk) disable iff (!presetn) rx_valid && !rx_accept);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // nbu_uart
`default_nettype wire

// ==== hdl/nbu_consts.svh ====
`ifndef NBU_CONSTS_SVH
`define NBU_CONSTS_SVH
// register byte offsets
`define NBU_OFS_CTRL 8'h00
`define NBU_OFS_BUF 8'h04
`define NBU_OFS_PWR 8'h08
`define NBU_OFS_STAT 8'h0C
`define NBU_OFS_MASK 8'h10
// serial_control_reg fields
`define NBU_RX_DONE 0
`define NBU_TX_DONE 1
`define NBU_RX_NINTH 2
`define NBU_TX_NINTH 3
`define NBU_REN 4
`define NBU_MPROC 5
`define NBU_VAR 6
`define NBU_T2SEL 7
// power_control_reg field
`define NBU_DOUBLE 7
// interrupt status and mask fields
`define NBU_IRQ_RX 0
`define NBU_IRQ_TX 1
// reset values
`define NBU_CTRL_RST 8'h00
`define NBU_PWR_RST 8'h00
`define NBU_IRQ_RST 2'h0
// sample ticks per bit minus one, and the mid-bit tick
`define NBU_TICK_LAST 4'hF
`define NBU_TICK_MID 4'h7
// clocks per sample tick minus one: /64 and /32 bit rates
`define NBU_FIX_SLOW 3'h3
`define NBU_FIX_FAST 3'h1
// bit indices of a character
`define NBU_IDX_NINTH 4'h9
`define NBU_IDX_STOP 4'hA
`define NBU_IDX_DATA_LAST 4'h8
// index once the stop bit has gone out
`define NBU_IDX_DONE 4'hB
`endif

// ==== hdl/nbu_pkg.sv ====
`default_nettype none
package nbu_pkg;
	// one received character
	typedef struct packed
	{
		logic ninth;
		logic [7:0] data;
	} nbu_char_type;
	// transmitter states
	typedef enum logic [0:0]
	{
		NBU_TX_IDLE = 1'b0,
		NBU_TX_SHIFT = 1'b1
	} nbu_tx_type;
	// receiver states
	typedef enum logic [1:0]
	{
		NBU_RX_IDLE = 2'b00,
		NBU_RX_START = 2'b01,
		NBU_RX_BITS = 2'b10,
		NBU_RX_STOP = 2'b11
	} nbu_rx_type;
endpackage
`default_nettype wire

// ==== hdl/nbu_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.svh"
module nbu_baud
	import nbu_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// rate selection
	input wire logic variable_rate,
	input wire logic use_timer2,
	input wire logic baud_double_bit,
	// timer overflow pulses
	input wire logic tmr1_ovf,
	input wire logic tmr2_ovf,
	// sixteen ticks per bit
	output logic tick
);
	logic [2:0] div; // fixed-rate clock divider
	logic t1_half; // timer 1 overflow halver
	logic [2:0] div_last;

	assign div_last = baud_double_bit ? `NBU_FIX_FAST : `NBU_FIX_SLOW;

	// fixed-rate divider, free running so both directions share it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div <= 3'h0;
		else if (div >= div_last)
			div <= 3'h0;
		else
			div <= div + 3'h1;
	end

	// timer 1 overflows count half unless the rate is doubled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			t1_half <= 1'b0;
		else if (tmr1_ovf)
			t1_half <= ~t1_half;
	end

	// tick selection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick <= 1'b0;
		else if (!variable_rate)
			tick <= (div >= div_last); // [RL12]
		else if (use_timer2)
			tick <= tmr2_ovf; // [RL14]
		else
			tick <= tmr1_ovf & (baud_double_bit | t1_half); // [RL14]
	end

	property p_fixed_slow;
		@(posedge pclk) disable iff (!presetn)
		(tick && !variable_rate && !baud_double_bit) ##1 (!variable_rate && !baud_double_bit)[*4]
			|-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3);
	endproperty
	a_fixed_slow: assert property (p_fixed_slow) else $error("fixed slow tick spacing wrong"); // [RL12]

	property p_timer2;
		@(posedge pclk) disable iff (!presetn)
		(variable_rate && use_timer2 && tmr2_ovf) |=> tick;
	endproperty
	a_timer2: assert property (p_timer2) else $error("timer 2 overflow gave no tick"); // [RL14]
endmodule // nbu_baud
`default_nettype wire

// ==== hdl/nbu_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.svh"
module nbu_rx
	import nbu_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic rx_enable,
	input wire logic tick,
	// serial line
	input wire logic rxd,
	// received character
	output nbu_char_type rx_char,
	output logic rx_valid
);
	nbu_rx_type state; // receiver state
	logic [3:0] cnt; // sample ticks within a bit
	logic [3:0] idx; // data bit index
	logic [8:0] shreg; // ninth bit lands at the top

	// receive sequencer; stop bit is not checked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= NBU_RX_IDLE;
			cnt <= 4'h0;
			idx <= 4'h0;
			shreg <= 9'h000;
			rx_char <= '0;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (tick)
			begin
				cnt <= cnt + 4'h1;
				unique case (state)
					NBU_RX_IDLE:
					begin
						cnt <= 4'h0;
						if (rx_enable && !rxd) // [RL7]
							state <= NBU_RX_START;
					end
					NBU_RX_START:
						if (cnt == `NBU_TICK_MID)
						begin
							// a glitch shorter than half a bit is no start
							cnt <= 4'h0;
							idx <= 4'h0;
							state <= rxd ? NBU_RX_IDLE : NBU_RX_BITS;
						end
					NBU_RX_BITS:
						if (cnt == `NBU_TICK_LAST)
						begin
							shreg <= {rxd, shreg[8:1]}; // lsb first [RL2]
							idx <= idx + 4'h1;
							if (idx == `NBU_IDX_DATA_LAST)
								state <= NBU_RX_STOP;
						end
					NBU_RX_STOP:
						if (cnt == `NBU_TICK_LAST)
						begin
							// mid stop bit: hand over whatever it holds [RL4]
							rx_char <= '{ninth: shreg[8], data: shreg[7:0]};
							rx_valid <= 1'b1;
							state <= NBU_RX_IDLE;
						end
				endcase
			end
		end
	end

	property p_no_start;
		@(posedge pclk) disable iff (!presetn)
		(state == NBU_RX_IDLE && !rx_enable) |=> (state == NBU_RX_IDLE);
	endproperty
	a_no_start: assert property (p_no_start) else $error("receiver started while disabled"); // [RL7]
endmodule // nbu_rx
`default_nettype wire

// ==== verif/nbu_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-end transceiver: decodes txd, sends characters on rxd
module nbu_remote
	import nbu_pkg::*;
(
	// clock
	input wire logic pclk,
	// serial lines
	input wire logic txd,
	output logic rxd
);
	logic [8:0] got_char; // last decoded data plus ninth bit
	logic got_stop; // stop level seen mid stop bit
	int got_len = 0; // measured first data bit length in clocks
	int got_count = 0; // characters decoded so far
	int k;
	// line idles high like a pulled-up wire
	initial rxd = 1'b1;
	// decoder: first data bit must be one then zero; its length is one exact bit time
	always
	begin
		@(negedge txd);
		while (txd === 1'b0)
			@(posedge pclk);
		got_len = 0;
		while (txd === 1'b1)
		begin
			@(posedge pclk);
			got_len++;
		end
		got_char[0] = (got_len != 0);
		// one clock into the second data bit now
		repeat (got_len / 2 - 1) @(posedge pclk);
		for (k = 1; k < 9; k++) // d1..d7 then ninth
		begin
			got_char[k] = txd;
			if (k < 8)
				repeat (got_len) @(posedge pclk);
		end
		// counted mid ninth bit, so the stop bit still lies ahead
		got_count++;
		repeat (got_len) @(posedge pclk);
		got_stop = txd;
	end
	// sender: start, nine bits lsb first, stop
	task automatic send_char(input logic [8:0] c, input int len);
		rxd <= 1'b0;
		repeat (len) @(posedge pclk);
		for (int i = 0; i < 9; i++)
		begin
			rxd <= c[i];
			repeat (len) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (len) @(posedge pclk);
	endtask
endmodule // nbu_remote
`default_nettype wire

// ==== verif/nbu_uart_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.svh"
module nbu_uart_test
	import nbu_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, txd, irq, rxd;
	logic tmr1_ovf = 1'b0;
	logic tmr2_ovf = 1'b0;
	logic [1:0] ovf_mode = 2'h0; // 1 timer1 pulses, 2 timer2 pulses
	logic ovf_phase = 1'b0;
	logic [31:0] q;
	logic e;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;

	nbu_uart nbu_uart_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tmr1_ovf(tmr1_ovf), .tmr2_ovf(tmr2_ovf), .rxd(rxd), .txd(txd), .irq(irq));
	nbu_remote nbu_remote_i (.pclk(pclk), .txd(txd), .rxd(rxd));

	always #2 pclk = ~pclk;
	// overflow pulses every second clock, plus the hang guard
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		ovf_phase <= ~ovf_phase;
		tmr1_ovf <= (ovf_mode == 2'h1) && ovf_phase;
		tmr2_ovf <= (ovf_mode == 2'h2) && ovf_phase;
		if (cycles == 20000)
		begin
			err_count++;
			complete_run;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, then an idle cycle so no signal is set twice in a step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, q, e);
		check(q, exp);
	endtask
	// send one byte and follow it on the line; the done flag must rise only at the stop bit
	task xmit(input logic [7:0] d, input logic [8:0] exp, input int len);
		int c0;
		c0 = nbu_remote_i.got_count;
		wr(`NBU_OFS_BUF, {24'h00_0000, d});
		// the far end counts the character in the middle of its ninth bit
		while (nbu_remote_i.got_count == c0)
			@(posedge pclk);
		check({23'h00_0000, nbu_remote_i.got_char}, {23'h00_0000, exp});
		check(nbu_remote_i.got_len, len);
		apb(1'b0, `NBU_OFS_CTRL, 32'h0000_0000, q, e);
		check({31'h0000_0000, q[`NBU_TX_DONE]}, 32'h0000_0000);
		repeat (len / 2) @(posedge pclk);
		apb(1'b0, `NBU_OFS_CTRL, 32'h0000_0000, q, e);
		check({31'h0000_0000, q[`NBU_TX_DONE]}, 32'h0000_0001);
		check({31'h0000_0000, txd}, 32'h0000_0001);
		repeat (len) @(posedge pclk);
		check({31'h0000_0000, nbu_remote_i.got_stop}, 32'h0000_0001);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values and an unmapped place
		rd(`NBU_OFS_CTRL, 32'h0000_0000);
		rd(`NBU_OFS_PWR, 32'h0000_0000);
		apb(1'b0, 8'h14, 32'h0000_0000, q, e);
		check({31'h0000_0000, e}, 32'h0000_0001);
		// slow fixed rate, ninth bit one, interrupt unmasked
		wr(`NBU_OFS_MASK, 32'h0000_0003);
		wr(`NBU_OFS_CTRL, 32'h0000_0008);
		xmit(8'hA5, 9'h1A5, 64);
		check({31'h0000_0000, irq}, 32'h0000_0001);
		rd(`NBU_OFS_STAT, 32'h0000_0002);
		rd(`NBU_OFS_STAT, 32'h0000_0000);
		// doubled rate, ninth bit zero, tx event masked out
		wr(`NBU_OFS_CTRL, 32'h0000_0000);
		wr(`NBU_OFS_MASK, 32'h0000_0001);
		wr(`NBU_OFS_PWR, 32'h0000_0080);
		xmit(8'h3D, 9'h03D, 32);
		check({31'h0000_0000, irq}, 32'h0000_0000);
		rd(`NBU_OFS_STAT, 32'h0000_0002);
		wr(`NBU_OFS_PWR, 32'h0000_0000);
		wr(`NBU_OFS_MASK, 32'h0000_0003);
		// receive with the done flag clear, then while it is still set
		wr(`NBU_OFS_CTRL, 32'h0000_0010);
		nbu_remote_i.send_char(9'h15A, 64);
		rd(`NBU_OFS_CTRL, 32'h0000_0015);
		rd(`NBU_OFS_BUF, 32'h0000_005A);
		check({31'h0000_0000, irq}, 32'h0000_0001);
		rd(`NBU_OFS_STAT, 32'h0000_0001);
		nbu_remote_i.send_char(9'h011, 64);
		rd(`NBU_OFS_BUF, 32'h0000_005A);
		rd(`NBU_OFS_STAT, 32'h0000_0000);
		// address filter: ninth zero dropped, ninth one kept
		wr(`NBU_OFS_CTRL, 32'h0000_0030);
		nbu_remote_i.send_char(9'h077, 64);
		rd(`NBU_OFS_CTRL, 32'h0000_0030);
		nbu_remote_i.send_char(9'h1C3, 64);
		rd(`NBU_OFS_CTRL, 32'h0000_0035);
		rd(`NBU_OFS_BUF, 32'h0000_00C3);
		rd(`NBU_OFS_STAT, 32'h0000_0001);
		// receiver off ignores the line
		wr(`NBU_OFS_CTRL, 32'h0000_0000);
		nbu_remote_i.send_char(9'h155, 64);
		rd(`NBU_OFS_STAT, 32'h0000_0000);
		rd(`NBU_OFS_BUF, 32'h0000_00C3);
		// timer driven rates: timer2 one tick per overflow, timer1 every second one
		wr(`NBU_OFS_CTRL, 32'h0000_00C8);
		ovf_mode <= 2'h2;
		xmit(8'h81, 9'h181, 32);
		wr(`NBU_OFS_CTRL, 32'h0000_0040);
		ovf_mode <= 2'h1;
		xmit(8'h05, 9'h005, 64);
		complete_run;
	end
endmodule // nbu_uart_test
`default_nettype wire
